// *** rtl/qdd_frame_decoder.v ***
// serial command frame decoder with channel registers and code-to-level mapping
// What this block does
// R1: frames are exactly twenty-four bits, MSB first
// R2: first serial bit received becomes frame bit 23
// R3: bit 23 selects read or write access
// R4: host keeps bit 22 zero; reserved
// R5: bits 21..19 pick data/range/power/control register
// R6: bits 18..16 pick channel A-D or all
// R7: bits 15..0 are the data field
// R8: every target supports both write and read
// R9: offset binary: 0x800 is zero level
// R10: twos complement: zero code is zero level
// R11: unipolar ranges use straight binary codes
// R12: act only on complete frames, else discard
// R13: static input picks bipolar coding; unipolar straight
`timescale 1ns/1ns
`include "qdd_map.vh"

module qdd_frame_decoder #(
  parameter NUM_CH = 4,
  parameter CODE_W = 12
) (
  input wire I_CORE_CLK,
  input wire I_RESETN,
  input wire I_SCLK,
  input wire I_SYNC_N,
  input wire I_SERIAL_DATA_IN,
  input wire I_CODING_TWOS,
  output reg O_FRAME_STROBE,
  output reg O_WRITE_STROBE,
  output reg O_READ_STROBE,
  output reg O_RESERVED_ERR,
  output reg [2:0] O_TARGET_SEL,
  output reg [2:0] O_CHANNEL_SEL,
  output reg [15:0] O_FRAME_DATA,
  output reg [15:0] O_READ_DATA,
  output wire [NUM_CH-1:0] O_BIPOLAR,
  output wire [NUM_CH*(CODE_W+1)-1:0] O_LEVEL
);

  // three-stage samplers for the link pins; only stage two feeds stage three
  reg [2:0] sclk_sync_reg;
  reg [2:0] sync_sync_reg;
  reg [2:0] din_sync_reg;
  reg sclk_flt_reg;
  reg sync_flt_reg;
  reg din_flt_reg;
  wire sclk_agree;
  wire sync_agree;
  wire din_agree;
  wire sclk_fall;
  wire sync_fall;
  wire sync_rise;

  always @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      sclk_sync_reg <= 3'h0;
      sync_sync_reg <= 3'h7;
      din_sync_reg <= 3'h0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], I_SCLK};
      sync_sync_reg <= {sync_sync_reg[1:0], I_SYNC_N};
      din_sync_reg <= {din_sync_reg[1:0], I_SERIAL_DATA_IN};
    end
  end

  // a change counts only once the second and third stages agree
  assign sclk_agree = (sclk_sync_reg[1] == sclk_sync_reg[2]);
  assign sync_agree = (sync_sync_reg[1] == sync_sync_reg[2]);
  assign din_agree = (din_sync_reg[1] == din_sync_reg[2]);
  assign sclk_fall = sclk_agree & sclk_flt_reg & ~sclk_sync_reg[2];
  assign sync_fall = sync_agree & sync_flt_reg & ~sync_sync_reg[2];
  assign sync_rise = sync_agree & ~sync_flt_reg & sync_sync_reg[2];

  always @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      sclk_flt_reg <= 1'b0;
      sync_flt_reg <= 1'b1;
      din_flt_reg <= 1'b0;
    end else begin
      if (sclk_agree) begin
        sclk_flt_reg <= sclk_sync_reg[2];
      end
      if (sync_agree) begin
        sync_flt_reg <= sync_sync_reg[2];
      end
      if (din_agree) begin
        din_flt_reg <= din_sync_reg[2];
      end
    end
  end

  // serial command frame shifter; data is taken on the falling serial clock edge
  reg [`QDD_FRAME_BITS-1:0] frame_reg;
  reg [`QDD_CNT_W-1:0] bit_cnt_reg;
  wire in_frame;
  wire frame_done;

  assign in_frame = ~sync_flt_reg;

  always @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      frame_reg <= {`QDD_FRAME_BITS{1'b0}};
      bit_cnt_reg <= {`QDD_CNT_W{1'b0}};
    end else if (sync_fall) begin
      bit_cnt_reg <= {`QDD_CNT_W{1'b0}};
    end else if (in_frame && sclk_fall) begin
      // R2: MSB first shift
      frame_reg <= {frame_reg[`QDD_FRAME_BITS-2:0], din_flt_reg};
      // R1: count saturates past 24 so long frames are seen
      if (bit_cnt_reg != `QDD_CNT_MAX) begin
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
    end
  end

  // R12: only a frame of exactly 24 bits ends in an action
  assign frame_done = sync_rise && (bit_cnt_reg == `QDD_CNT_FULL);

  // frame field split
  wire frame_read;
  wire [2:0] tgt_sel;
  wire [2:0] ch_sel;
  wire [15:0] data_fld;
  // R3: direction flag
  assign frame_read = frame_reg[`QDD_BIT_RW];
  // R5: target select field
  assign tgt_sel = frame_reg[`QDD_TGT_HI:`QDD_TGT_LO];
  // R6: channel address field
  assign ch_sel = frame_reg[`QDD_CH_HI:`QDD_CH_LO];
  // R7: data field
  assign data_fld = frame_reg[`QDD_DATA_HI:`QDD_DATA_LO];

  // target registers written by complete write frames
  reg [15:0] dac_data_reg [0:NUM_CH-1];
  reg [2:0] range_reg [0:NUM_CH-1];
  reg [15:0] power_reg;
  reg [15:0] ctrl_reg;
  wire wr_ok;
  assign wr_ok = frame_done & ~frame_read;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_ch
      wire ch_hit;
      wire [CODE_W-1:0] code;
      wire bipolar;
      reg [CODE_W:0] level_reg;
      reg [CODE_W:0] level_next;
      // R6: single channel or broadcast to all four
      assign ch_hit = (ch_sel == ch[2:0]) || (ch_sel == `QDD_CH_ALL);

      always @(posedge I_CORE_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
          dac_data_reg[ch] <= `QDD_RST_DATA;
          range_reg[ch] <= `QDD_RST_RANGE;
        end else if (wr_ok && ch_hit) begin
          // R5: route by target select
          if (tgt_sel == `QDD_TGT_DATA) begin
            dac_data_reg[ch] <= data_fld;
          end
          if (tgt_sel == `QDD_TGT_RANGE) begin
            range_reg[ch] <= data_fld[2:0];
          end
        end
      end

      // only the upper twelve data bits carry the code; the rest are don't care
      assign code = dac_data_reg[ch][`QDD_CODE_HI:`QDD_CODE_LO];
      assign bipolar = (range_reg[ch] >= `QDD_RANGE_BIPOLAR_MIN) && (range_reg[ch] <= `QDD_RANGE_BIPOLAR_MAX);
      assign O_BIPOLAR[ch] = bipolar;

      // signed level in steps from zero output
      always @* begin
        level_next = {1'b0, code};
        if (!bipolar) begin
          // R11: straight binary
          level_next = {1'b0, code};
        end else if (I_CODING_TWOS) begin
          // R13: coding picked by static input
          // R10: code is already signed
          level_next = {code[CODE_W-1], code};
        end else begin
          // R9: midscale code is the zero level
          level_next = {1'b0, code} - `QDD_MID_CODE;
        end
      end

      always @(posedge I_CORE_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
          level_reg <= {(CODE_W+1){1'b0}};
        end else begin
          level_reg <= level_next;
        end
      end
      assign O_LEVEL[ch*(CODE_W+1) +: CODE_W+1] = level_reg;
    end
  endgenerate

  // power and control targets are chip wide; power ignores the channel field, control takes it as a sub-command
  always @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      power_reg <= `QDD_RST_POWER;
      ctrl_reg <= `QDD_RST_CTRL;
    end else if (wr_ok) begin
      if (tgt_sel == `QDD_TGT_POWER) begin
        power_reg <= data_fld;
      end
      if (tgt_sel == `QDD_TGT_CTRL && ch_sel == `QDD_CH_B) begin
        ctrl_reg <= data_fld;
      end
    end
  end

  // readback selection; a broadcast read returns channel A
  reg [15:0] rd_next;
  reg [1:0] rd_ch;
  always @* begin
    rd_ch = (ch_sel == `QDD_CH_ALL) ? 2'h0 : ch_sel[1:0];
    case (tgt_sel)
      `QDD_TGT_DATA: rd_next = dac_data_reg[rd_ch];
      `QDD_TGT_RANGE: rd_next = {13'h0000, range_reg[rd_ch]};
      `QDD_TGT_POWER: rd_next = power_reg;
      `QDD_TGT_CTRL: rd_next = ctrl_reg;
      default: rd_next = 16'h0000;
    endcase
  end

  // decoded frame outputs; strobes last one cycle, fields hold until the next frame
  always @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_FRAME_STROBE <= 1'b0;
      O_WRITE_STROBE <= 1'b0;
      O_READ_STROBE <= 1'b0;
      O_RESERVED_ERR <= 1'b0;
      O_TARGET_SEL <= 3'h0;
      O_CHANNEL_SEL <= 3'h0;
      O_FRAME_DATA <= 16'h0000;
      O_READ_DATA <= 16'h0000;
    end else begin
      O_FRAME_STROBE <= frame_done;
      // R3: write or read by direction flag
      O_WRITE_STROBE <= frame_done & ~frame_read;
      O_READ_STROBE <= frame_done & frame_read;
      if (frame_done) begin
        // R4: a set reserved bit is flagged, the frame still acts
        O_RESERVED_ERR <= frame_reg[`QDD_BIT_ZERO];
        O_TARGET_SEL <= tgt_sel;
        O_CHANNEL_SEL <= ch_sel;
        O_FRAME_DATA <= data_fld;
        // R8: read returns stored target value
        if (frame_read) begin
          O_READ_DATA <= rd_next;
        end
      end
    end
  end

endmodule // qdd_frame_decoder

// *** rtl/qdd_map.vh ***
// field layout, decode codes and reset values of the serial frame decoder
`ifndef QDD_MAP_VH
`define QDD_MAP_VH

`define QDD_FRAME_BITS 24
`define QDD_CNT_W 5
`define QDD_CNT_MAX 5'h19
`define QDD_CNT_FULL 5'h18

`define QDD_BIT_RW 23
`define QDD_BIT_ZERO 22
`define QDD_TGT_HI 21
`define QDD_TGT_LO 19
`define QDD_CH_HI 18
`define QDD_CH_LO 16
`define QDD_DATA_HI 15
`define QDD_DATA_LO 0

`define QDD_TGT_DATA 3'h0
`define QDD_TGT_RANGE 3'h1
`define QDD_TGT_POWER 3'h2
`define QDD_TGT_CTRL 3'h3

`define QDD_CH_A 3'h0
`define QDD_CH_B 3'h1
`define QDD_CH_C 3'h2
`define QDD_CH_D 3'h3
`define QDD_CH_ALL 3'h4

`define QDD_CODE_HI 15
`define QDD_CODE_LO 4
`define QDD_RANGE_BIPOLAR_MIN 3'h3
`define QDD_RANGE_BIPOLAR_MAX 3'h5
`define QDD_MID_CODE 13'h0800

`define QDD_RST_DATA 16'h0000
`define QDD_RST_RANGE 3'h0
`define QDD_RST_POWER 16'h0000
`define QDD_RST_CTRL 16'h0000

`endif

// *** dv/qdd_monitor.sv ***
// port checker for the serial frame decoder
`timescale 1ns/1ns
module qdd_monitor #(parameter NUM_CH = 4, parameter CODE_W = 12) (
  input wire I_CORE_CLK,
  input wire I_RESETN,
  input wire I_SCLK,
  input wire I_SYNC_N,
  input wire I_SERIAL_DATA_IN,
  input wire I_CODING_TWOS,
  input wire O_FRAME_STROBE,
  input wire O_WRITE_STROBE,
  input wire O_READ_STROBE,
  input wire O_RESERVED_ERR,
  input wire [2:0] O_TARGET_SEL,
  input wire [2:0] O_CHANNEL_SEL,
  input wire [15:0] O_FRAME_DATA,
  input wire [15:0] O_READ_DATA,
  input wire [NUM_CH-1:0] O_BIPOLAR,
  input wire [NUM_CH*(CODE_W+1)-1:0] O_LEVEL
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESETN);
  property p_dir; O_FRAME_STROBE |-> O_WRITE_STROBE ^ O_READ_STROBE; endproperty
  a_dir: assert property (p_dir) else $error("bad direction strobe");
  property p_cause; O_WRITE_STROBE || O_READ_STROBE |-> O_FRAME_STROBE; endproperty
  a_cause: assert property (p_cause) else $error("access without frame");
  property p_pulse; O_FRAME_STROBE |=> !O_FRAME_STROBE [*3]; endproperty
  a_pulse: assert property (p_pulse) else $error("strobe too long");
  // a frame only counts once select has been high a while
  property p_late; O_FRAME_STROBE |-> I_SYNC_N && $past(I_SYNC_N, 4); endproperty
  a_late: assert property (p_late) else $error("strobe inside frame");
  property p_hold; !O_FRAME_STROBE |-> $stable({O_TARGET_SEL, O_CHANNEL_SEL, O_FRAME_DATA}); endproperty
  a_hold: assert property (p_hold) else $error("fields moved");
  property p_rd; !O_READ_STROBE |-> $stable(O_READ_DATA); endproperty
  a_rd: assert property (p_rd) else $error("read data moved");
  property p_uni; !$past(O_BIPOLAR[0]) |-> !O_LEVEL[CODE_W]; endproperty
  a_uni: assert property (p_uni) else $error("unipolar level negative");
  property p_lvl; !$past(O_WRITE_STROBE) && $past(I_CODING_TWOS) == $past(I_CODING_TWOS, 2) |-> $stable(O_LEVEL);
  endproperty
  a_lvl: assert property (p_lvl) else $error("level moved");
endmodule // qdd_monitor
bind qdd_frame_decoder qdd_monitor #(.NUM_CH(NUM_CH), .CODE_W(CODE_W)) i_qdd_monitor (.*);

// *** dv/qdd_host_model.sv ***
// host model that shifts command frames into the decoder
`timescale 1ns/1ns
module qdd_host_model (
  output logic o_sclk,
  output logic o_sync_n,
  output logic o_serial_data_in
);
  // serial clock idles high and stands still between frames
  initial begin
    o_sclk = 1;
    o_sync_n = 1;
    o_serial_data_in = 0;
  end
  // frame sent msb first exactly as the caller gives it
  // non-blocking updates: a change that lands on a core edge never races the samplers
  task send(input logic [23:0] f, input int n);
    o_sync_n <= 0;
    for (int i = 0; i < n; i++) begin
      o_serial_data_in <= (i < 24) ? f[23-i] : 1'b0;
      #63 o_sclk <= 0;
      #62 o_sclk <= 1;
    end
    // released line shows the inverse so stale bits never look valid
    #63 o_serial_data_in <= ~o_serial_data_in;
    o_sync_n <= 1;
  endtask
endmodule // qdd_host_model

// *** dv/qdd_frame_decoder_tb.sv ***
// self-checking bench for the serial frame decoder
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; $display("[FAIL] %0t got %h", $time, a); end end
module qdd_frame_decoder_tb;
  logic clk = 0, rst_n = 0, twos = 0, wr_seen;
  wire sclk, sync_n, sdata, fs, ws, rs, err;
  wire [2:0] tgt, ch;
  wire [15:0] fd, rd;
  wire [3:0] bip;
  wire [51:0] lvl;
  int miscompares = 0, samples_checked = 0, nstb = 0;
  typedef struct packed {logic [23:0] f; logic [15:0] rd;} row_t;
  row_t rows[16] = '{'{24'h041230, 0}, '{24'h008000, 0}, '{24'h080003, 0}, '{24'h015670, 0}, '{24'h02abc0, 0},
    '{24'h10000f, 0}, '{24'h190005, 0}, '{24'h800000, 16'h8000}, '{24'h830000, 16'h1230},
    '{24'h880000, 16'h0003}, '{24'h900000, 16'h000f}, '{24'h990000, 16'h0005}, '{24'h810000, 16'h5670},
    '{24'h820000, 16'habc0}, '{24'h840000, 16'h8000}, '{24'h8b0000, 16'h0000}};
  qdd_host_model i_qdd_host_model (.o_sclk(sclk), .o_sync_n(sync_n), .o_serial_data_in(sdata));
  qdd_frame_decoder i_qdd_frame_decoder (.I_CORE_CLK(clk), .I_RESETN(rst_n), .I_SCLK(sclk), .I_SYNC_N(sync_n),
    .I_SERIAL_DATA_IN(sdata), .I_CODING_TWOS(twos), .O_FRAME_STROBE(fs), .O_WRITE_STROBE(ws), .O_READ_STROBE(rs),
    .O_RESERVED_ERR(err), .O_TARGET_SEL(tgt), .O_CHANNEL_SEL(ch), .O_FRAME_DATA(fd), .O_READ_DATA(rd),
    .O_BIPOLAR(bip), .O_LEVEL(lvl));
  // core clock, 4 ns period
  initial forever #2 clk = ~clk;
  // count frames the decoder accepted and note their direction
  always @(posedge clk) if (fs === 1'b1) begin
    nstb <= nstb + 1;
    wr_seen <= ws;
  end
  // one frame of n bits, then the strobe count must move by exp
  task frame(input logic [23:0] f, input int n, input int exp);
    int c;
    c = nstb;
    i_qdd_host_model.send(f, n);
    repeat (10) @(posedge clk);
    `CHK(nstb - c, exp)
  endtask
  task stop_test;
    $display("checked %0d, miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog: the whole run needs well under 100 us
  initial begin
    #300000;
    miscompares++;
    stop_test;
  end
  initial begin
    repeat (3) @(posedge clk);
    `CHK({fd, rd, lvl, fs}, 85'h0)
    rst_n <= 1;
    repeat (4) @(posedge clk);
    foreach (rows[k]) begin
      frame(rows[k].f, 24, 1);
      `CHK({tgt, ch, fd, wr_seen}, {rows[k].f[21:0], ~rows[k].f[23]})
      if (rows[k].f[23]) `CHK(rd, rows[k].rd)
    end
    // A bipolar mid code, B C D unipolar
    `CHK({lvl, bip}, {13'h0123, 13'h0abc, 13'h0567, 13'h0000, 4'h1})
    twos <= 1;
    repeat (3) @(posedge clk);
    `CHK(lvl, {13'h0123, 13'h0abc, 13'h0567, 13'h1800})
    // short and long frames leave channel B alone
    frame(24'h01ffff, 23, 0);
    frame(24'h01ffff, 25, 0);
    frame(24'h810000, 24, 1);
    `CHK(rd, 16'h5670)
    frame(24'hc00000, 24, 1);
    `CHK({err, rd}, {1'b1, 16'h8000})
    rst_n <= 0;
    repeat (2) @(posedge clk);
    `CHK({lvl, err}, 53'h0)
    stop_test;
  end
endmodule // qdd_frame_decoder_tb
